/* hdl/dtc_pkg.sv */
// Constants shared by the dual timer/counter block.
// Assumes an 8-bit special-function space reached by direct addresses.

package dtc_pkg;

	// Register addresses
	localparam logic [7:0] SFR_TCTL = 8'h88;
	localparam logic [7:0] SFR_TMODE = 8'h89;
	localparam logic [7:0] SFR_CNT0_LO = 8'h8A;
	localparam logic [7:0] SFR_CNT1_LO = 8'h8B;
	localparam logic [7:0] SFR_CNT0_HI = 8'h8C;
	localparam logic [7:0] SFR_CNT1_HI = 8'h8D;
	localparam logic [4:0] TCTL_BIT_BASE = 5'h11;
	localparam logic [7:0] UNMAPPED_READ = 8'hFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Flag register bit positions, timer one sits two bits above timer zero
	localparam int POS_TYPE0 = 0;
	localparam int POS_XDET0 = 1;
	localparam int POS_RUN0 = 4;
	localparam int POS_OVF0 = 5;
	localparam int CH_STEP = 2;

	// Mode register nibble layout
	localparam int NIB_W = 4;
	localparam int TM_GATE = 3;
	localparam int TM_CT = 2;

	// Internal clock divider, counts of system cycles per tick
	localparam logic [3:0] DIV_FAST_CYC = 4'h4;
	localparam logic [3:0] DIV_SLOW_CYC = 4'hC;
	localparam logic [3:0] SLOW_LAST = DIV_SLOW_CYC - 4'h1;
	localparam logic [1:0] FAST_LAST = 2'(DIV_FAST_CYC - 4'h1);

	// Operating modes
	typedef enum logic [1:0] {
		MODE_PRESCALE = 2'b00,
		MODE_FULL = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT = 2'b11
	} dtc_mode_t;

endpackage

/* hdl/dtc_timer.sv */
// Next-count logic of one timer: low and high count bytes per mode.
// Assumes the caller gates the increments and handles register writes.
`timescale 1ns/1ps

module dtc_timer
	import dtc_pkg::*;
(
	input wire dtc_mode_t mode,
	input wire logic inc_low,
	input wire logic inc_high,
	input wire logic [7:0] low_q,
	input wire logic [7:0] high_q,
	output logic [7:0] next_low,
	output logic [7:0] next_high,
	output logic ovf_low,
	output logic ovf_high
);

	logic [13:0] sum13;
	logic [16:0] sum16;
	logic [8:0] sum_lo;
	logic [8:0] sum_hi;

	// Candidate increments for each width
	assign sum13 = {1'b0, high_q, low_q[4:0]} + 14'h0001;
	assign sum16 = {1'b0, high_q, low_q} + 17'h0_0001;
	assign sum_lo = {1'b0, low_q} + 9'h001;
	assign sum_hi = {1'b0, high_q} + 9'h001;

	////////////////////////////////////////////////////////////////
	// Mode selection
	always_comb begin
		next_low = low_q;
		next_high = high_q;
		ovf_low = 1'b0;
		ovf_high = 1'b0;
		case (mode)
			MODE_PRESCALE: begin
				if (inc_low) begin
					next_low = {low_q[7:5], sum13[4:0]};
					next_high = sum13[12:5];
					ovf_low = sum13[13];
				end
			end
			MODE_FULL: begin
				if (inc_low) begin
					next_low = sum16[7:0];
					next_high = sum16[15:8];
					ovf_low = sum16[16];
				end
			end
			MODE_RELOAD: begin
				if (inc_low) begin
					next_low = sum_lo[8] ? high_q : sum_lo[7:0];
					ovf_low = sum_lo[8];
				end
			end
			MODE_SPLIT: begin
				if (inc_low) begin
					next_low = sum_lo[7:0];
					ovf_low = sum_lo[8];
				end
				if (inc_high) begin
					next_high = sum_hi[7:0];
					ovf_high = sum_hi[8];
				end
			end
			default: begin
				next_low = low_q;
			end
		endcase
	end

endmodule // dtc_timer

/* hdl/dtc_top.sv */
// Dual timer/counter with external interrupt detection and its registers.
// Assumes a direct-address register port and synchronous pin inputs.
`timescale 1ns/1ps

module dtc_top
	import dtc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [7:0] bit_addr,
	input wire logic bit_wr,
	input wire logic bit_rd,
	input wire logic bit_wdata,
	output logic bit_rdata,
	input wire logic [1:0] ext_irq_pin_n,
	input wire logic [1:0] count_pin,
	input wire logic timer_zero_clock_divider_select,
	input wire logic timer_one_clock_divider_select,
	input wire logic [1:0] timer_vec_ack,
	input wire logic [1:0] ext_irq_vec_ack,
	output logic timer_zero_overflow_flag,
	output logic timer_one_overflow_flag,
	output logic ext_irq_zero_detect_flag,
	output logic ext_irq_one_detect_flag
);

	logic [7:0] timer_run_and_irq_flags;
	logic [7:0] timer_mode_config;
	logic [7:0] timer_zero_count_low;
	logic [7:0] timer_one_count_low;
	logic [7:0] timer_zero_count_high;
	logic [7:0] timer_one_count_high;
	logic [3:0] psc;
	logic [3:0] next_psc;
	logic [1:0] pin_prev;
	logic [1:0] cnt_prev;
	logic tick_fast;
	logic tick_slow;
	logic [1:0] div_sel;
	logic [1:0] div_tick;
	logic [1:0] run;
	logic [1:0] gate;
	logic [1:0] ct;
	logic [1:0] src_tick;
	logic [1:0] en;
	logic [1:0] inc_low;
	logic [1:0] inc_high;
	logic [1:0] ovf_low;
	logic [1:0] ovf_high;
	logic [1:0] tf_set;
	logic [1:0] next_ext;
	dtc_mode_t md [2];
	logic [7:0] nx_low [2];
	logic [7:0] nx_high [2];
	logic [7:0] cur_low [2];
	logic [7:0] cur_high [2];
	logic wr_tctl;
	logic wr_tmode;
	logic wr_lo0;
	logic wr_lo1;
	logic wr_hi0;
	logic wr_hi1;
	logic bit_hit;
	logic [7:0] bit_mask;
	logic [7:0] wmask;
	logic [7:0] wdat;
	logic [7:0] sw_tctl;
	logic [7:0] next_tctl;
	logic [7:0] next_rdata;
	logic next_bit_rdata;
	logic [7:0] next_lo0;
	logic [7:0] next_lo1;
	logic [7:0] next_hi0;
	logic [7:0] next_hi1;
	logic split0;
	logic nowr0;
	logic nowr1;

	////////////////////////////////////////////////////////////////
	// Register port decode
	// direct addresses only
	assign wr_tctl = sfr_wr && (sfr_addr == SFR_TCTL);
	assign wr_tmode = sfr_wr && (sfr_addr == SFR_TMODE);
	assign wr_lo0 = sfr_wr && (sfr_addr == SFR_CNT0_LO);
	assign wr_lo1 = sfr_wr && (sfr_addr == SFR_CNT1_LO);
	assign wr_hi0 = sfr_wr && (sfr_addr == SFR_CNT0_HI);
	assign wr_hi1 = sfr_wr && (sfr_addr == SFR_CNT1_HI);
	assign nowr0 = !(wr_lo0 || wr_hi0);
	assign nowr1 = !(wr_lo1 || wr_hi1);

	assign bit_hit = (bit_addr[7:3] == TCTL_BIT_BASE);
	assign bit_mask = 8'h01 << bit_addr[2:0];
	assign wmask = wr_tctl ? 8'hFF : ((bit_wr && bit_hit) ? bit_mask : 8'h00);
	assign wdat = wr_tctl ? sfr_wdata : {8{bit_wdata}};
	assign sw_tctl = (timer_run_and_irq_flags & ~wmask) | (wdat & wmask);

	assign next_rdata = (sfr_addr == SFR_TCTL) ? timer_run_and_irq_flags :
		(sfr_addr == SFR_TMODE) ? timer_mode_config :
		(sfr_addr == SFR_CNT0_LO) ? timer_zero_count_low :
		(sfr_addr == SFR_CNT1_LO) ? timer_one_count_low :
		(sfr_addr == SFR_CNT0_HI) ? timer_zero_count_high :
		(sfr_addr == SFR_CNT1_HI) ? timer_one_count_high : UNMAPPED_READ;
	assign next_bit_rdata = bit_hit ? timer_run_and_irq_flags[bit_addr[2:0]] : 1'b1;

	////////////////////////////////////////////////////////////////
	// Internal clock divider
	// ticks every 4 or 12 cycles
	assign next_psc = (psc == SLOW_LAST) ? 4'h0 : psc + 4'h1;
	assign tick_slow = (psc == SLOW_LAST);
	assign tick_fast = (psc[1:0] == FAST_LAST);
	assign div_sel = {timer_one_clock_divider_select, timer_zero_clock_divider_select};

	// Split state of timer zero
	assign split0 = (md[0] == MODE_SPLIT);
	assign cur_low[0] = timer_zero_count_low;
	assign cur_low[1] = timer_one_count_low;
	assign cur_high[0] = timer_zero_count_high;
	assign cur_high[1] = timer_one_count_high;

	////////////////////////////////////////////////////////////////
	// Per-timer count enables, interrupt inputs and flag bits
	for (genvar i = 0; i < 2; i++) begin : g_ch
		assign md[i] = dtc_mode_t'(timer_mode_config[NIB_W*i +: 2]);
		assign gate[i] = timer_mode_config[NIB_W*i + TM_GATE];
		assign ct[i] = timer_mode_config[NIB_W*i + TM_CT];
		assign run[i] = timer_run_and_irq_flags[POS_RUN0 + CH_STEP*i];
		assign div_tick[i] = div_sel[i] ? tick_fast : tick_slow;
		assign src_tick[i] = ct[i] ? (cnt_prev[i] && !count_pin[i]) : div_tick[i];
		assign en[i] = run[i] && (!gate[i] || ext_irq_pin_n[i]);
		assign next_ext[i] = timer_run_and_irq_flags[POS_TYPE0 + CH_STEP*i] ?
			((pin_prev[i] && !ext_irq_pin_n[i]) ||
			(!ext_irq_vec_ack[i] && sw_tctl[POS_XDET0 + CH_STEP*i])) :
			!ext_irq_pin_n[i];
		assign next_tctl[POS_OVF0 + CH_STEP*i] = tf_set[i] ||
			(!timer_vec_ack[i] && sw_tctl[POS_OVF0 + CH_STEP*i]);
		assign next_tctl[POS_RUN0 + CH_STEP*i] = sw_tctl[POS_RUN0 + CH_STEP*i];
		// flag tracks pin in level mode
		assign next_tctl[POS_XDET0 + CH_STEP*i] = next_ext[i];
		assign next_tctl[POS_TYPE0 + CH_STEP*i] = sw_tctl[POS_TYPE0 + CH_STEP*i];

		dtc_timer u_timer (
			.mode(md[i]),
			.inc_low(inc_low[i]),
			.inc_high(inc_high[i]),
			.low_q(cur_low[i]),
			.high_q(cur_high[i]),
			.next_low(nx_low[i]),
			.next_high(nx_high[i]),
			.ovf_low(ovf_low[i]),
			.ovf_high(ovf_high[i])
		);
	end

	// timer one stops in split mode
	assign inc_low[0] = en[0] && src_tick[0];
	assign inc_low[1] = en[1] && src_tick[1] && (md[1] != MODE_SPLIT);
	// high byte on timer one run bit
	assign inc_high[0] = run[1] && div_tick[0];
	assign inc_high[1] = 1'b0;
	assign tf_set[0] = ovf_low[0];
	assign tf_set[1] = split0 ? ovf_high[0] : ovf_low[1];

	// Software writes win over counting
	assign next_lo0 = wr_lo0 ? sfr_wdata : nx_low[0];
	assign next_hi0 = wr_hi0 ? sfr_wdata : nx_high[0];
	assign next_lo1 = wr_lo1 ? sfr_wdata : nx_low[1];
	assign next_hi1 = wr_hi1 ? sfr_wdata : nx_high[1];

	// Flag outputs
	assign timer_zero_overflow_flag = timer_run_and_irq_flags[POS_OVF0];
	assign timer_one_overflow_flag = timer_run_and_irq_flags[POS_OVF0 + CH_STEP];
	assign ext_irq_zero_detect_flag = timer_run_and_irq_flags[POS_XDET0];
	assign ext_irq_one_detect_flag = timer_run_and_irq_flags[POS_XDET0 + CH_STEP];

	////////////////////////////////////////////////////////////////
	// Control and mode registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timer_run_and_irq_flags <= RESET_BYTE;
			timer_mode_config <= RESET_BYTE;
		end else begin
			timer_run_and_irq_flags <= next_tctl;
			timer_mode_config <= wr_tmode ? sfr_wdata : timer_mode_config;
		end
	end

	// Count registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timer_zero_count_low <= RESET_BYTE;
			timer_zero_count_high <= RESET_BYTE;
			timer_one_count_low <= RESET_BYTE;
			timer_one_count_high <= RESET_BYTE;
		end else begin
			timer_zero_count_low <= next_lo0;
			timer_zero_count_high <= next_hi0;
			timer_one_count_low <= next_lo1;
			timer_one_count_high <= next_hi1;
		end
	end

	// Divider and pin history, pins idle high
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			psc <= 4'h0;
			pin_prev <= 2'b11;
			cnt_prev <= 2'b11;
		end else begin
			psc <= next_psc;
			pin_prev <= ext_irq_pin_n;
			cnt_prev <= count_pin;
		end
	end

	// Read data, loaded on a read strobe
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sfr_rdata <= UNMAPPED_READ;
			bit_rdata <= 1'b1;
		end else begin
			sfr_rdata <= sfr_rd ? next_rdata : sfr_rdata;
			bit_rdata <= bit_rd ? next_bit_rdata : bit_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_quiet3;
		!tick_fast [*3];
	endsequence

	sequence s_fast_period;
		s_quiet3 ##1 tick_fast;
	endsequence

	chk_fast_divider: assert property (tick_fast |=> s_fast_period)
		else $error("fast divider tick not every four cycles");

	chk_ovf_sets_flag: assert property (
		ovf_low[0] |=> timer_zero_overflow_flag)
		else $error("timer zero overflow did not set its flag");

	chk_ack_clears_flag: assert property (
		timer_vec_ack[0] && !tf_set[0] |=> !timer_zero_overflow_flag)
		else $error("vectoring did not clear timer zero flag");

	chk_stop_holds: assert property (
		!run[0] && nowr0 && !split0 |=> $stable(timer_zero_count_low) &&
		$stable(timer_zero_count_high))
		else $error("timer zero moved while stopped");

	chk_gate_blocks: assert property (
		gate[0] && !ext_irq_pin_n[0] && nowr0 && !split0 |=>
		$stable(timer_zero_count_low))
		else $error("gated timer counted with pin low");

	chk_free_run: assert property (
		run[0] && !gate[0] && src_tick[0] && md[0] == MODE_FULL && nowr0 |=>
		timer_zero_count_low == 8'($past(timer_zero_count_low) + 8'h01))
		else $error("ungated running timer did not count");

	chk_pin_count: assert property (
		en[1] && ct[1] && cnt_prev[1] && !count_pin[1] && md[1] == MODE_FULL &&
		nowr1 |=> timer_one_count_low == 8'($past(timer_one_count_low) + 8'h01))
		else $error("counter missed a falling pin edge");

	chk_prescale_carry: assert property (
		inc_low[0] && md[0] == MODE_PRESCALE && timer_zero_count_low[4:0] == 5'h1F &&
		nowr0 |=> timer_zero_count_high == 8'($past(timer_zero_count_high) + 8'h01))
		else $error("prescaler carry lost");

	chk_full_carry: assert property (
		inc_low[1] && md[1] == MODE_FULL && timer_one_count_low == 8'hFF && nowr1
		|=> timer_one_count_low == 8'h00 &&
		timer_one_count_high == 8'($past(timer_one_count_high) + 8'h01))
		else $error("sixteen bit carry lost");

	chk_reload: assert property (
		inc_low[0] && md[0] == MODE_RELOAD && timer_zero_count_low == 8'hFF &&
		nowr0 |=> timer_zero_count_low == $past(timer_zero_count_high))
		else $error("reload value wrong");

	chk_split_low: assert property (
		inc_low[0] && split0 && timer_zero_count_low == 8'hFF && nowr0 |=>
		timer_zero_count_low == 8'h00 && timer_zero_overflow_flag)
		else $error("split low byte did not wrap");

	chk_t1_frozen: assert property (
		md[1] == MODE_SPLIT && nowr1 |=> $stable(timer_one_count_low) &&
		$stable(timer_one_count_high))
		else $error("timer one moved in mode three");

	chk_split_high: assert property (
		split0 && run[1] && div_tick[0] && timer_zero_count_high == 8'hFF &&
		nowr0 |=> timer_one_overflow_flag)
		else $error("split high overflow missed");

	chk_edge_detect: assert property (
		timer_run_and_irq_flags[POS_TYPE0] && pin_prev[0] && !ext_irq_pin_n[0] |=>
		ext_irq_zero_detect_flag)
		else $error("falling edge not flagged");

	chk_level_follow: assert property (
		!timer_run_and_irq_flags[POS_TYPE0 + CH_STEP] |=>
		ext_irq_one_detect_flag == !$past(ext_irq_pin_n[1]))
		else $error("level flag does not follow pin");

	chk_bit_write: assert property (
		bit_wr && !wr_tctl && bit_addr == 8'h8C |=> run[0] == $past(bit_wdata) &&
		run[1] == $past(run[1]) && timer_mode_config == $past(timer_mode_config))
		else $error("bit write disturbed other bits");

	chk_unmapped_ones: assert property (
		sfr_rd && sfr_addr == 8'h8F |=> sfr_rdata == UNMAPPED_READ)
		else $error("unmapped read not all ones");

endmodule // dtc_top

/* tb/dtc_pin_model.sv */
// Pin-side model: count pulse bursts and registered interrupt pin levels.
// Assumes bursts are requested by a one-cycle go pulse from the bench.
`timescale 1ns/1ps

module dtc_pin_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic go,
	input wire logic ch,
	input wire logic [3:0] len,
	input wire logic [1:0] lvl_n,
	output logic [1:0] count_pin,
	output logic [1:0] irq_n
);
	logic [4:0] left;
	logic phase;
	logic sel;

	// Burst counter, each half period of a pulse lasts two cycles
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			left <= 5'h00;
			phase <= 1'b0;
			sel <= 1'b0;
			irq_n <= 2'b11;
		end else begin
			irq_n <= lvl_n;
			phase <= go ? 1'b0 : ~phase;
			if (go) begin
				left <= {len, 1'b0};
				sel <= ch;
			end else if (phase && left != 5'h00) begin
				left <= left - 5'h01;
			end
		end
	end

	// Idle pins rest high on their pull-ups; odd counts pull the chosen pin low
	assign count_pin = left[0] ? (sel ? 2'b01 : 2'b10) : 2'b11;
endmodule // dtc_pin_model

/* tb/dual_timer_counter_tb_top.sv */
// Self-checking bench for the dual timer/counter and its interrupt flags.
// Assumes the pin model drives the count and interrupt pins.
`timescale 1ns/1ps

module dual_timer_counter_tb_top
	import dtc_pkg::*;
;
	logic ref_clk, nrst, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, bit_rdata;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, d;
	logic [1:0] lvl_n, count_pin, irq_n, t_ack, x_ack;
	logic div0, div1, go, bch, ovf0, ovf1, xdet0, xdet1;
	logic [3:0] blen;
	int error_cnt, check_count;

	dtc_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr),
		.bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
		.ext_irq_pin_n(irq_n), .count_pin(count_pin),
		.timer_zero_clock_divider_select(div0), .timer_one_clock_divider_select(div1),
		.timer_vec_ack(t_ack), .ext_irq_vec_ack(x_ack), .timer_zero_overflow_flag(ovf0),
		.timer_one_overflow_flag(ovf1), .ext_irq_zero_detect_flag(xdet0),
		.ext_irq_one_detect_flag(xdet1));

	dtc_pin_model i_pins (.ref_clk(ref_clk), .nrst(nrst), .go(go), .ch(bch), .len(blen),
		.lvl_n(lvl_n), .count_pin(count_pin), .irq_n(irq_n));

	////////////////////////////////////////////////////////////////////////////////
	// Comparison and bus tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask

	// Read data is registered, so it is settled at the following falling edge
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge ref_clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		rd(a);
		check(d, exp, what);
	endtask

	task automatic bwr(input int b, input logic v);
		@(negedge ref_clk);
		bit_addr = SFR_TCTL + 8'(b);
		bit_wdata = v;
		bit_wr = 1'b1;
		@(negedge ref_clk);
		bit_wr = 1'b0;
	endtask

	task automatic brd(input logic [7:0] a);
		@(negedge ref_clk);
		bit_addr = a;
		bit_rd = 1'b1;
		@(negedge ref_clk);
		bit_rd = 1'b0;
		d = {7'h00, bit_rdata};
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Run bit high for exactly k cycles, so k count decisions are made
	task automatic window(input int b, input int k);
		bwr(b, 1'b1);
		cyc(k - 2);
		bwr(b, 1'b0);
	endtask

	task automatic ack(input logic ext, input int ch);
		@(negedge ref_clk);
		if (ext) x_ack[ch] = 1'b1;
		else t_ack[ch] = 1'b1;
		@(negedge ref_clk);
		x_ack = 2'b00;
		t_ack = 2'b00;
	endtask

	function automatic logic [7:0] fl(input int ch);
		return {7'h00, ch ? xdet1 : xdet0};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		for (int a = 8'h88; a < 8'h8E; a++) begin
			rdchk(8'(a), RESET_BYTE, "reset value");
		end
		rdchk(8'h8E, UNMAPPED_READ, "unmapped byte");
		rdchk(8'h8F, UNMAPPED_READ, "last unmapped byte");
		brd(8'h90);
		check(d, 8'h01, "unmapped bit");
	endtask

	task automatic t_regs();
		for (int a = 1; a < 6; a++) begin
			wr(SFR_TCTL + 8'(a), 8'h5A ^ 8'(a));
			rdchk(SFR_TCTL + 8'(a), 8'h5A ^ 8'(a), "write back");
		end
		bwr(POS_TYPE0 + CH_STEP, 1'b1);
		rdchk(SFR_TCTL, 8'h04, "bit set");
		bwr(POS_TYPE0, 1'b1);
		rdchk(SFR_TCTL, 8'h05, "second bit");
		bwr(POS_TYPE0 + CH_STEP, 1'b0);
		brd(SFR_TCTL);
		check(d, 8'h01, "bit read");
		wr(SFR_TCTL, 8'h00);
	endtask

	task automatic t_full();
		wr(SFR_TMODE, 8'h01);
		wr(SFR_CNT0_LO, 8'hFE);
		wr(SFR_CNT0_HI, 8'hFF);
		div0 = 1'b1;
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'h0A, "full low");
		rdchk(SFR_CNT0_HI, 8'h00, "full high");
		check({7'h00, ovf0}, 8'h01, "overflow");
		cyc(20);
		rdchk(SFR_CNT0_LO, 8'h0A, "stopped");
		ack(1'b0, 0);
		check({7'h00, ovf0}, 8'h00, "vector clear");
		bwr(POS_OVF0, 1'b1);
		check({7'h00, ovf0}, 8'h01, "soft set");
		bwr(POS_OVF0, 1'b0);
		check({7'h00, ovf0}, 8'h00, "soft clear");
	endtask

	task automatic t_gate();
		wr(SFR_TMODE, 8'h09);
		wr(SFR_CNT0_LO, 8'h00);
		wr(SFR_CNT0_HI, 8'h00);
		lvl_n = 2'b10;
		cyc(3);
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'h00, "gated low");
		lvl_n = 2'b11;
		cyc(3);
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'h0C, "gated high");
		wr(SFR_TMODE, 8'h01);
		lvl_n = 2'b10;
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'h18, "ungated");
		lvl_n = 2'b11;
	endtask

	task automatic t_count();
		wr(SFR_TMODE, 8'h50);
		wr(SFR_CNT1_LO, 8'h00);
		bwr(POS_RUN0 + CH_STEP, 1'b1);
		@(negedge ref_clk);
		bch = 1'b1;
		blen = 4'h5;
		go = 1'b1;
		@(negedge ref_clk);
		go = 1'b0;
		cyc(30);
		bwr(POS_RUN0 + CH_STEP, 1'b0);
		rdchk(SFR_CNT1_LO, 8'h05, "pin edges");
		// Timer one on its fast divider, wrapping all sixteen bits
		wr(SFR_TMODE, 8'h10);
		wr(SFR_CNT1_LO, 8'hFA);
		wr(SFR_CNT1_HI, 8'hFF);
		div1 = 1'b1;
		window(POS_RUN0 + CH_STEP, 48);
		rdchk(SFR_CNT1_LO, 8'h06, "timer one low");
		rdchk(SFR_CNT1_HI, 8'h00, "timer one high");
		check({7'h00, ovf1}, 8'h01, "timer one flag");
		bwr(POS_OVF0 + CH_STEP, 1'b0);
	endtask

	task automatic t_mode0();
		div0 = 1'b0;
		wr(SFR_TMODE, 8'h00);
		wr(SFR_CNT0_LO, 8'hFF);
		wr(SFR_CNT0_HI, 8'h00);
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'hE3, "prescale low");
		rdchk(SFR_CNT0_HI, 8'h01, "slow divider");
	endtask

	task automatic t_reload();
		div0 = 1'b1;
		wr(SFR_TMODE, 8'h02);
		wr(SFR_CNT0_HI, 8'hFD);
		wr(SFR_CNT0_LO, 8'hFD);
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'hFD, "reloaded");
		rdchk(SFR_CNT0_HI, 8'hFD, "reload source");
		check({7'h00, ovf0}, 8'h01, "reload flag");
		bwr(POS_OVF0, 1'b0);
	endtask

	task automatic t_split();
		wr(SFR_TMODE, 8'h33);
		wr(SFR_CNT0_LO, 8'hF8);
		wr(SFR_CNT0_HI, 8'hFC);
		wr(SFR_CNT1_LO, 8'h20);
		wr(SFR_CNT1_HI, 8'h30);
		window(POS_RUN0 + CH_STEP, 48);
		rdchk(SFR_CNT0_HI, 8'h08, "split high");
		check({7'h00, ovf1}, 8'h01, "split flag");
		check({7'h00, ovf0}, 8'h00, "low flag");
		rdchk(SFR_CNT0_LO, 8'hF8, "low held");
		rdchk(SFR_CNT1_LO, 8'h20, "t1 low held");
		rdchk(SFR_CNT1_HI, 8'h30, "t1 high held");
		window(POS_RUN0, 48);
		rdchk(SFR_CNT0_LO, 8'h04, "split low");
		check({7'h00, ovf0}, 8'h01, "split low flag");
	endtask

	task automatic t_ext();
		for (int ch = 0; ch < 2; ch++) begin
			lvl_n[ch] = 1'b0;
			cyc(3);
			check(fl(ch), 8'h01, "level set");
			ack(1'b1, ch);
			check(fl(ch), 8'h01, "level kept");
			lvl_n[ch] = 1'b1;
			cyc(3);
			check(fl(ch), 8'h00, "level follows");
			bwr(POS_TYPE0 + ch * CH_STEP, 1'b1);
			cyc(2);
			check(fl(ch), 8'h00, "edge idle");
			lvl_n[ch] = 1'b0;
			cyc(3);
			check(fl(ch), 8'h01, "edge set");
			lvl_n[ch] = 1'b1;
			cyc(3);
			check(fl(ch), 8'h01, "edge held");
			ack(1'b1, ch);
			check(fl(ch), 8'h00, "edge vector");
			bwr(POS_TYPE0 + ch * CH_STEP, 1'b0);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, clock, watchdog and main sequence
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// The whole run needs under three thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		{nrst, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, go, bch, div0, div1} = '0;
		{sfr_addr, sfr_wdata, bit_addr, blen, t_ack, x_ack} = '0;
		lvl_n = 2'b11;
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		t_reset();
		$display("test reset done");
		t_regs();
		$display("test registers done");
		t_full();
		$display("test full count done");
		t_gate();
		$display("test gating done");
		t_count();
		$display("test counter done");
		t_mode0();
		$display("test prescale done");
		t_reload();
		$display("test reload done");
		t_split();
		$display("test split done");
		t_ext();
		$display("test external flags done");
		complete_run();
	end
endmodule // dual_timer_counter_tb_top
